// ### core/mspwm_top.sv
// Master/slave PWM pair with an Avalon-MM register slave.
// Assumes a single 25 MHz clock and a synchronous active-low reset.
// Operation
// RULE1: Slave polarity 0 gives active-high output, 1 gives active-low.
// RULE2: Software sets the slave output-mode bit to 1.
// RULE3: Software leaves the master output-mode bit at 0.
// RULE4: Master polarity stays 0 while the master output-mode bit is 0.
// RULE5: Slave operation-mode field 100B selects one-count mode.
// RULE6: Retrigger bit 1 lets the slave accept a trigger while counting.
// RULE7: Slave trigger select 100B picks the master count-complete event.
// RULE8: Software writes 0 to the slave master/split bit.
// RULE9: Master/split bit is fixed 0 on upper odd channels, split bit on lower.
// RULE10: Software gives the slave the same clock select as the master.
// RULE11: Slave edge select is unused and written as 00B.
// RULE12: The slave level bit directly drives the slave output pin.
// RULE13: With output enable 1 the counting drives the slave pin.
// RULE14: Unpowered, the unit has no count clock and ignores writes.
// RULE15: Power enable starts the clock and writes, with channels stopped.
// RULE16: Software programs the prescaler before configuring channels.
// RULE17: Software loads period and duty before starting.
// RULE18: While stopped, the slave output holds its programmed level.
// RULE19: Start bits are set together and clear themselves.
// RULE20: Start sets both enabled flags; master event fires and starts slave. The code fires it only when master mode bit 0 (MD_RETRIG) is 1.
// RULE21: Software sets slave output enable at start only when resuming.
// RULE22: Master at zero raises its event, reloads period and keeps counting.
// RULE23: Triggered slave loads duty, counts to zero, raises event, waits.
// RULE24: Output goes active one count after trigger, inactive at zero.
// RULE25: Stop holds both counters and leaves the slave output as it is.
// RULE26: Duty above period keeps the output active the whole period.
`timescale 1ns/1ps

module mspwm_top #(
   parameter int SLAVE_CH = 1
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Avalon-MM slave.
   input wire mspwm_pkg::mspwm_avreq_s i_avs,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // PWM pin and channel events.
   output logic o_slave_pwm_out,
   output logic o_master_done_irq,
   output logic o_slave_done_irq
);

   initial
   begin
      if (SLAVE_CH < 1 || SLAVE_CH > 7 || (SLAVE_CH % 2) == 0)
      begin
         $error("mspwm_top: SLAVE_CH must be an odd channel 1 to 7");
      end
   end

   // ==================================================================
   // Declarations.
   localparam logic [15:0] S_MODE_MASK = (SLAVE_CH >= 5) ? 16'hf7ff : 16'hffff;

   logic wait_q;
   logic [31:0] rdata_q;
   logic pwr_q;
   logic [7:0] presc_q;
   logic [15:0] m_mode_q;
   logic [15:0] s_mode_q;
   logic [15:0] period_q;
   logic [15:0] duty_q;
   logic [15:0] m_cnt_q;
   logic [15:0] s_cnt_q;
   logic m_en_q;
   logic s_en_q;
   // Enabled flags, one bit per channel; each half has its own process.
   wire [1:0] en_q = {s_en_q, m_en_q};
   logic [1:0] lvl_q;
   logic [1:0] oe_q;
   logic [1:0] pol_q;
   logic [1:0] om_q;
   logic s_run_q;
   logic m_irq_q;
   logic s_irq_q;
   logic tick0;
   logic tick1;

   // ==================================================================
   // Bus decode.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a[7:2] == ofs[7:2];
   endfunction

   // Pick the channel count clock from the high bit (CKS_HI) of its clock select field.
   function automatic logic ck_pick(input logic [15:0] mode, input logic t0,
                                    input logic t1);
      return mode[mspwm_pkg::CKS_HI] ? t1 : t0;
   endfunction

   // Access is taken at the edge where waitrequest is low.
   wire acc = (i_avs.read || i_avs.write) && !wait_q;
   wire wr = acc && i_avs.write;
   wire [7:0] adr = i_avs.address;
   wire [31:0] wd = i_avs.writedata;
   wire wr_pwr = wr && hit(adr, mspwm_pkg::OFS_PWR_EN);
   wire wr_ok = wr && pwr_q; // see RULE14
   wire wr_start = wr_ok && hit(adr, mspwm_pkg::OFS_START);
   wire wr_stop = wr_ok && hit(adr, mspwm_pkg::OFS_STOP);
   wire wr_lvl = wr_ok && hit(adr, mspwm_pkg::OFS_OUT_LEVEL);
   wire wr_oe = wr_ok && hit(adr, mspwm_pkg::OFS_OUT_ENABLE);

   // Channel registers are cleared whenever the unit is unpowered.
   wire ch_rst = !i_rst_n || !pwr_q; // see RULE14

   // Start and stop are write pulses only; they are never stored.
   wire m_start = wr_start && wd[mspwm_pkg::CH_M]; // see RULE19
   wire s_start = wr_start && wd[mspwm_pkg::CH_S]; // see RULE19
   wire m_stop = wr_stop && wd[mspwm_pkg::CH_M];
   wire s_stop = wr_stop && wd[mspwm_pkg::CH_S];

   // ==================================================================
   // Mode decode and count-clock selection.
   wire m_interval = m_mode_q[mspwm_pkg::MD_LSB +: 3] == mspwm_pkg::MD_INTERVAL;
   wire s_onecount = s_mode_q[mspwm_pkg::MD_LSB +: 3] == mspwm_pkg::MD_ONE_COUNT; // see RULE5
   wire s_retrig = s_mode_q[mspwm_pkg::MD_RETRIG];
   wire s_from_m = s_mode_q[mspwm_pkg::STS_LSB +: 3] == mspwm_pkg::STS_MASTER_IRQ; // see RULE7
   wire m_tick = ck_pick(m_mode_q, tick0, tick1); // see RULE10
   wire s_tick = ck_pick(s_mode_q, tick0, tick1); // see RULE10

   // Slave trigger: master event or, without it, its own start bit.
   wire s_trig = en_q[mspwm_pkg::CH_S] && s_onecount &&
                 (s_from_m ? m_irq_q : s_start); // see RULE7
   wire s_accept = s_trig && (!s_run_q || s_retrig); // see RULE6
   wire s_count = en_q[mspwm_pkg::CH_S] && s_run_q && s_tick && !s_accept;
   wire s_zero = s_count && s_cnt_q == 16'h0000;

   // Counting owns the pin only in slave output mode with output enabled.
   // A stop that lands on a count edge freezes the pin with the counter.
   wire pwm_ctl = oe_q[mspwm_pkg::CH_S] && om_q[mspwm_pkg::CH_S] &&
                  en_q[mspwm_pkg::CH_S] && !s_stop; // see RULE13, RULE2, RULE25
   wire go_act = pwm_ctl && s_count && !s_zero; // see RULE24
   wire go_idle = pwm_ctl && s_zero; // see RULE24

   // Write data masked for the mode field that is fixed on upper channels.
   wire [15:0] s_mode_wd = wd[15:0] & S_MODE_MASK; // see RULE9

   // Read data selection.
   wire [31:0] rd_word =
      hit(adr, mspwm_pkg::OFS_PWR_EN) ? {31'h0, pwr_q} :
      hit(adr, mspwm_pkg::OFS_PRESCALE) ? {24'h0, presc_q} :
      hit(adr, mspwm_pkg::OFS_M_MODE) ? {16'h0, m_mode_q} :
      hit(adr, mspwm_pkg::OFS_S_MODE) ? {16'h0, s_mode_q} :
      hit(adr, mspwm_pkg::OFS_M_PERIOD) ? {16'h0, period_q} :
      hit(adr, mspwm_pkg::OFS_S_DUTY) ? {16'h0, duty_q} :
      hit(adr, mspwm_pkg::OFS_M_COUNT) ? {16'h0, m_cnt_q} :
      hit(adr, mspwm_pkg::OFS_S_COUNT) ? {16'h0, s_cnt_q} :
      hit(adr, mspwm_pkg::OFS_ENABLED) ? {30'h0, en_q} :
      hit(adr, mspwm_pkg::OFS_OUT_LEVEL) ? {30'h0, lvl_q} :
      hit(adr, mspwm_pkg::OFS_OUT_ENABLE) ? {30'h0, oe_q} :
      hit(adr, mspwm_pkg::OFS_OUT_POL) ? {30'h0, pol_q} :
      hit(adr, mspwm_pkg::OFS_OUT_MODE) ? {30'h0, om_q} : 32'h00000000;

   // ==================================================================
   // Bus handshake: one wait cycle, then one cycle with waitrequest low.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         wait_q <= !((i_avs.read || i_avs.write) && wait_q);
         rdata_q <= rd_word;
      end
   end

   // Peripheral power enable is writable at any time.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         pwr_q <= 1'b0;
      end
      else if (wr_pwr)
      begin
         pwr_q <= wd[0]; // see RULE15
      end
   end

   // Configuration registers; modes are frozen while the channel runs.
   always_ff @(posedge i_clk)
   begin
      if (ch_rst)
      begin
         presc_q <= mspwm_pkg::RST_PRESCALE;
         m_mode_q <= mspwm_pkg::RST_WORD16;
         s_mode_q <= mspwm_pkg::RST_WORD16;
         period_q <= mspwm_pkg::RST_WORD16;
         duty_q <= mspwm_pkg::RST_WORD16;
         pol_q <= mspwm_pkg::RST_BITS2;
         om_q <= mspwm_pkg::RST_BITS2;
      end
      else if (wr_ok)
      begin
         if (hit(adr, mspwm_pkg::OFS_PRESCALE))
            presc_q <= wd[7:0];
         if (hit(adr, mspwm_pkg::OFS_M_MODE) && !en_q[mspwm_pkg::CH_M])
            m_mode_q <= wd[15:0];
         if (hit(adr, mspwm_pkg::OFS_S_MODE) && !en_q[mspwm_pkg::CH_S])
            s_mode_q <= s_mode_wd; // see RULE9
         if (hit(adr, mspwm_pkg::OFS_M_PERIOD))
            period_q <= wd[15:0];
         if (hit(adr, mspwm_pkg::OFS_S_DUTY))
            duty_q <= wd[15:0];
         if (hit(adr, mspwm_pkg::OFS_OUT_POL))
            pol_q <= wd[1:0];
         if (hit(adr, mspwm_pkg::OFS_OUT_MODE))
            om_q <= wd[1:0];
      end
   end

   // Output enable register.
   always_ff @(posedge i_clk)
   begin
      if (ch_rst)
         oe_q <= mspwm_pkg::RST_BITS2;
      else if (wr_oe)
         oe_q <= wd[1:0];
   end

   // Master channel: interval timer that reloads at zero.
   always_ff @(posedge i_clk)
   begin
      m_irq_q <= 1'b0;
      if (ch_rst)
      begin
         m_en_q <= 1'b0; // see RULE15
         m_cnt_q <= mspwm_pkg::RST_WORD16;
      end
      else if (m_stop)
         m_en_q <= 1'b0; // see RULE25
      else if (m_start && m_interval)
      begin
         m_en_q <= 1'b1; // see RULE20
         m_cnt_q <= period_q;
         m_irq_q <= m_mode_q[mspwm_pkg::MD_RETRIG]; // see RULE20
      end
      else if (en_q[mspwm_pkg::CH_M] && m_tick)
      begin
         if (m_cnt_q == 16'h0000)
         begin
            m_cnt_q <= period_q; // see RULE22
            m_irq_q <= 1'b1; // see RULE22
         end
         else
            m_cnt_q <= m_cnt_q - 16'h0001;
      end
   end

   // Slave channel: one-count timer started by the trigger.
   always_ff @(posedge i_clk)
   begin
      s_irq_q <= 1'b0;
      if (ch_rst)
      begin
         s_en_q <= 1'b0; // see RULE15
         s_cnt_q <= mspwm_pkg::RST_WORD16;
         s_run_q <= 1'b0;
      end
      else if (s_stop)
         s_en_q <= 1'b0; // see RULE25
      else if (s_start && s_onecount && !en_q[mspwm_pkg::CH_S])
         s_en_q <= 1'b1; // see RULE20
      else if (s_accept)
      begin
         s_cnt_q <= duty_q; // see RULE23, RULE26
         s_run_q <= 1'b1;
      end
      else if (s_zero)
      begin
         s_run_q <= 1'b0; // see RULE23
         s_irq_q <= 1'b1; // see RULE23
      end
      else if (s_count)
         s_cnt_q <= s_cnt_q - 16'h0001;
   end

   // Output level: software owns it unless the slave output enable is set.
   always_ff @(posedge i_clk)
   begin
      if (ch_rst)
         lvl_q <= mspwm_pkg::RST_BITS2;
      else
      begin
         if (wr_lvl)
            lvl_q[mspwm_pkg::CH_M] <= wd[mspwm_pkg::CH_M];
         if (go_act)
            lvl_q[mspwm_pkg::CH_S] <= !pol_q[mspwm_pkg::CH_S]; // see RULE1
         else if (go_idle)
            lvl_q[mspwm_pkg::CH_S] <= pol_q[mspwm_pkg::CH_S]; // see RULE1
         else if (wr_lvl && !oe_q[mspwm_pkg::CH_S])
            lvl_q[mspwm_pkg::CH_S] <= wd[mspwm_pkg::CH_S]; // see RULE18
      end
   end

   // Shared prescaler, running only while the unit is powered.
   mspwm_prescale u_presc (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_run(pwr_q), // see RULE14
      .i_sel0(presc_q[3:0]),
      .i_sel1(presc_q[7:4]),
      .o_tick0(tick0),
      .o_tick1(tick1)
   );

   // Outputs straight from flip-flops.
   assign o_avs_readdata = rdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_slave_pwm_out = lvl_q[mspwm_pkg::CH_S]; // see RULE12
   assign o_master_done_irq = m_irq_q;
   assign o_slave_done_irq = s_irq_q;

   // ==================================================================
   // Assertions.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_lvl_write;
      wr_lvl && !oe_q[mspwm_pkg::CH_S] && !go_act && !go_idle;
   endsequence

   sequence s_master_wrap;
      en_q[mspwm_pkg::CH_M] && m_tick && m_cnt_q == 16'h0000 && !m_stop && !m_start;
   endsequence

   a_pol_active_level: assert property ( // see RULE1
      go_act |=> o_slave_pwm_out == !$past(pol_q[mspwm_pkg::CH_S]))
      else $error("active level does not follow polarity");

   a_onecount_only: assert property ( // see RULE5
      !s_onecount && !s_run_q |=> !s_run_q)
      else $error("slave ran outside one-count mode");

   a_retrig_reload: assert property ( // see RULE6
      s_accept && s_run_q && !s_stop |=> s_cnt_q == $past(duty_q))
      else $error("retrigger did not reload duty");

   a_trig_source: assert property ( // see RULE7
      m_irq_q && s_from_m && en_q[mspwm_pkg::CH_S] && !s_run_q && s_onecount
      && !s_stop && !ch_rst |=> s_run_q)
      else $error("master event did not start slave");

   a_split_fixed: assert property ( // see RULE9
      (SLAVE_CH >= 5) |-> !s_mode_q[mspwm_pkg::MS_BIT])
      else $error("fixed mode bit became set");

   a_level_write: assert property ( // see RULE12
      s_lvl_write |=> o_slave_pwm_out == $past(wd[mspwm_pkg::CH_S]))
      else $error("pin does not follow written level");

   a_unpowered_quiet: assert property ( // see RULE14
      !pwr_q && !wr_pwr |=> period_q == 16'h0000 && en_q == 2'h0 && !tick0)
      else $error("unpowered unit changed state");

   a_power_stopped: assert property ( // see RULE15
      $rose(pwr_q) |-> en_q == 2'h0 ##1 en_q == 2'h0 || $past(wr_start))
      else $error("channels not stopped at power-up");

   a_start_flags: assert property ( // see RULE20
      m_start && m_interval && !m_stop && pwr_q |=> en_q[mspwm_pkg::CH_M]
      && m_cnt_q == $past(period_q) && m_irq_q == $past(m_mode_q[0]))
      else $error("master start incomplete");

   a_master_reload: assert property ( // see RULE22
      s_master_wrap |=> m_irq_q && m_cnt_q == $past(period_q) ##1 !m_irq_q)
      else $error("master did not reload at zero");

   a_slave_done: assert property ( // see RULE23
      s_zero && !ch_rst && !s_stop |=> !s_run_q && s_irq_q ##1 !s_irq_q)
      else $error("slave did not end at zero");

   a_stop_holds: assert property ( // see RULE25
      m_stop && s_stop && !ch_rst && !(m_start || s_start) |=>
      $stable(o_slave_pwm_out) && $stable(s_cnt_q) && $stable(m_cnt_q))
      else $error("stop disturbed counters or pin");

   a_stopped_pin: assert property ( // see RULE18
      !en_q[mspwm_pkg::CH_S] && !wr_lvl && !ch_rst |=> $stable(o_slave_pwm_out))
      else $error("pin moved while stopped");

endmodule

// ### core/mspwm_pkg.sv
// Package for the master/slave PWM pair: register map, field layout,
// reset values and the bus request carrier.
// Assumes a byte-addressed 32-bit register bus with word-aligned registers.
package mspwm_pkg;

   // ==================================================================
   // Register byte offsets.
   localparam logic [7:0] OFS_PWR_EN = 8'h00;
   localparam logic [7:0] OFS_PRESCALE = 8'h04;
   localparam logic [7:0] OFS_M_MODE = 8'h08;
   localparam logic [7:0] OFS_S_MODE = 8'h0c;
   localparam logic [7:0] OFS_M_PERIOD = 8'h10;
   localparam logic [7:0] OFS_S_DUTY = 8'h14;
   localparam logic [7:0] OFS_M_COUNT = 8'h18;
   localparam logic [7:0] OFS_S_COUNT = 8'h1c;
   localparam logic [7:0] OFS_START = 8'h20;
   localparam logic [7:0] OFS_STOP = 8'h24;
   localparam logic [7:0] OFS_ENABLED = 8'h28;
   localparam logic [7:0] OFS_OUT_LEVEL = 8'h2c;
   localparam logic [7:0] OFS_OUT_ENABLE = 8'h30;
   localparam logic [7:0] OFS_OUT_POL = 8'h34;
   localparam logic [7:0] OFS_OUT_MODE = 8'h38;

   // ==================================================================
   // Channel bit positions in start, stop, status and output registers.
   localparam int CH_M = 0;
   localparam int CH_S = 1;

   // ==================================================================
   // Mode register fields.
   localparam int MD_LSB = 1;
   localparam int MD_RETRIG = 0;
   localparam int STS_LSB = 8;
   localparam int MS_BIT = 11;
   localparam int CKS_HI = 15;
   localparam logic [2:0] MD_INTERVAL = 3'h0;
   localparam logic [2:0] MD_ONE_COUNT = 3'h4;
   localparam logic [2:0] STS_MASTER_IRQ = 3'h4;

   // ==================================================================
   // Reset values and prescaler width.
   localparam logic [15:0] RST_WORD16 = 16'h0000;
   localparam logic [1:0] RST_BITS2 = 2'h0;
   localparam logic [7:0] RST_PRESCALE = 8'h00;
   localparam int PRESC_W = 15;

   // Bus request carrier.
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } mspwm_avreq_s;

endpackage

// ### core/mspwm_prescale.sv
// Prescaler that makes the two shared count-clock enables.
// Assumes one system clock; the enables are one-cycle pulses.
`timescale 1ns/1ps

module mspwm_prescale #(
   parameter int W = mspwm_pkg::PRESC_W
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Control.
   input wire logic i_run,
   input wire logic [3:0] i_sel0,
   input wire logic [3:0] i_sel1,
   // Count-clock enables.
   output logic o_tick0,
   output logic o_tick1
);

   initial
   begin
      if (W < 15 || W > 31)
      begin
         $error("mspwm_prescale: W out of range");
      end
   end

   logic [W-1:0] cnt_q;

   // A tick fires when the low sel bits of the divider are all ones.
   function automatic logic tick_of(input logic [W-1:0] c, input logic [3:0] s);
      logic [W-1:0] m;
      m = W'((32'h1 << s) - 32'h1);
      return (c & m) == m;
   endfunction

   // Free-running divider; halted while the unit is unpowered.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || !i_run)
      begin
         cnt_q <= '0;
         o_tick0 <= 1'b0;
         o_tick1 <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_q + W'(1);
         o_tick0 <= tick_of(cnt_q, i_sel0);
         o_tick1 <= tick_of(cnt_q, i_sel1);
      end
   end

endmodule

// ### bench/tb_top.sv
// Self-checking bench for the master/slave PWM pair: drives the register bus
// and measures the PWM pin and the channel events.
// Assumes the core package and mspwm_top are compiled first.
`timescale 1ns/1ps

module tb_top;
   // ==================================================================
   // Signals, counters and test values.
   logic i_clk;
   logic i_rst_n;
   mspwm_pkg::mspwm_avreq_s avs;
   logic [31:0] rdata;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest;
   logic o_slave_pwm_out;
   logic o_master_done_irq;
   logic o_slave_done_irq;
   logic [31:0] held;
   int error_cnt;
   int checks;
   localparam logic [31:0] PER = 32'h0000_0005;
   localparam logic [31:0] DUTY = 32'h0000_0002;
   localparam logic [31:0] S_MODE = 32'h0000_0409;
   localparam logic [31:0] M_MODE = 32'h0000_0001;

   // ==================================================================
   // Device under test.
   mspwm_top dut_u (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs(avs),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .o_slave_pwm_out(o_slave_pwm_out), .o_master_done_irq(o_master_done_irq),
      .o_slave_done_irq(o_slave_done_irq)
   );

   // Clock of 40 ns period.
   always #20 i_clk = ~i_clk;

   // ==================================================================
   // Shared tasks.
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic timeout(input string m);
      error_cnt++;
      $display("mismatch at %0t: timeout in %s", $time, m);
      tally_and_finish();
   endtask

   // One bus transfer; the request is held until waitrequest is sampled low.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge i_clk);
      avs <= '{address: a, read: !w, write: w, writedata: d};
      for (n = 0; n < 20; n++)
      begin
         @(posedge i_clk);
         if (o_avs_waitrequest === 1'b0)
            break;
      end
      rdata = o_avs_readdata;
      avs.read <= 1'b0;
      avs.write <= 1'b0;
      if (n == 20)
         timeout("bus transfer");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
      bus(a, 1'b0, 32'h0000_0000);
      chk(rdata, e, m);
   endtask

   task automatic wait_irq();
      int n;
      for (n = 0; n < 500; n++)
      begin
         @(posedge i_clk);
         if (o_master_done_irq === 1'b1)
            break;
      end
      if (n == 500)
         timeout("master event wait");
   endtask

   // Measures one period from a master event: length, active samples, first
   // active sample and slave events; si below zero skips the event count.
   task automatic measure(input int per, input int act, input logic lvl, input int si);
      int n;
      int hi;
      int first;
      int sc;
      wait_irq();
      hi = 0;
      sc = 0;
      first = 0;
      for (n = 1; n < 200; n++)
      begin
         @(posedge i_clk);
         if (o_slave_pwm_out === lvl && first == 0)
            first = n;
         if (o_slave_pwm_out === lvl)
            hi++;
         if (o_slave_done_irq === 1'b1)
            sc++;
         if (o_master_done_irq === 1'b1)
            break;
      end
      chk(n, per, "period length");
      chk(hi, act, "active length");
      if (si >= 0)
         chk(sc, si, "slave events per period");
      if (act < per)
         chk(first, 2, "first active sample");
   endtask

   // ==================================================================
   // Scenarios.
   task automatic t_power();
      int i;
      wr(mspwm_pkg::OFS_M_PERIOD, PER);
      rd(mspwm_pkg::OFS_M_PERIOD, 0, "write while unpowered");
      for (i = 0; i < 4; i++)
         rd(mspwm_pkg::OFS_OUT_LEVEL + 8'(4 * i), 0, "output reg reset");
      rd(8'h3c, 0, "unmapped read");
      wr(mspwm_pkg::OFS_PWR_EN, 1);
      rd(mspwm_pkg::OFS_ENABLED, 0, "channels stopped at power on");
      wr(mspwm_pkg::OFS_PRESCALE, 0);
      wr(mspwm_pkg::OFS_M_PERIOD, PER);
      wr(mspwm_pkg::OFS_S_DUTY, DUTY);
      rd(mspwm_pkg::OFS_M_PERIOD, PER, "write after power on");
      $display("test power done");
   endtask

   task automatic t_default();
      wr(mspwm_pkg::OFS_OUT_MODE, 2);
      wr(mspwm_pkg::OFS_OUT_POL, 0);
      wr(mspwm_pkg::OFS_OUT_LEVEL, 2);
      repeat (12) @(posedge i_clk);
      chk(o_slave_pwm_out, 1, "level one on pin");
      wr(mspwm_pkg::OFS_OUT_LEVEL, 0);
      repeat (12) @(posedge i_clk);
      chk(o_slave_pwm_out, 0, "level zero on pin");
      $display("test default level done");
   endtask

   task automatic t_run();
      wr(mspwm_pkg::OFS_M_MODE, M_MODE);
      wr(mspwm_pkg::OFS_S_MODE, S_MODE | 32'h0800);
      rd(mspwm_pkg::OFS_S_MODE, S_MODE | 32'h0800, "split bit writable");
      wr(mspwm_pkg::OFS_S_MODE, S_MODE);
      wr(mspwm_pkg::OFS_OUT_ENABLE, 2);
      wr(mspwm_pkg::OFS_START, 3);
      rd(mspwm_pkg::OFS_START, 0, "start bits clear");
      rd(mspwm_pkg::OFS_ENABLED, 3, "both enabled");
      measure(6, 2, 1'b1, 1);
      measure(6, 2, 1'b1, 1);
      wr(mspwm_pkg::OFS_STOP, 3);
      rd(mspwm_pkg::OFS_STOP, 0, "stop bits clear");
      rd(mspwm_pkg::OFS_ENABLED, 0, "both stopped");
      bus(mspwm_pkg::OFS_S_COUNT, 1'b0, 0);
      held = rdata;
      held[31] = o_slave_pwm_out;
      repeat (20) @(posedge i_clk);
      rd(mspwm_pkg::OFS_S_COUNT, {1'b0, held[30:0]}, "slave count held");
      chk(o_slave_pwm_out, held[31], "pin held after stop");
      $display("test run done");
   endtask

   task automatic t_polarity();
      wr(mspwm_pkg::OFS_OUT_POL, 2);
      wr(mspwm_pkg::OFS_PRESCALE, 1);
      wr(mspwm_pkg::OFS_START, 3);
      wait_irq(); // The start event is not tied to a tick edge; skip its period.
      measure(12, 4, 1'b0, 1);
      wr(mspwm_pkg::OFS_STOP, 3);
      $display("test polarity done");
   endtask

   task automatic t_full();
      wr(mspwm_pkg::OFS_OUT_POL, 0);
      wr(mspwm_pkg::OFS_PRESCALE, 0);
      wr(mspwm_pkg::OFS_S_DUTY, PER + 1);
      wr(mspwm_pkg::OFS_START, 3);
      wait_irq();
      measure(6, 6, 1'b1, -1);
      wr(mspwm_pkg::OFS_STOP, 3);
      $display("test full duty done");
   endtask

   // ==================================================================
   // Main sequence: reset for 6 cycles, then the scenarios.
   initial
   begin
      i_clk = 1'b0;
      i_rst_n = 1'b0;
      avs = '0;
      error_cnt = 0;
      checks = 0;
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_power();
      t_default();
      t_run();
      t_polarity();
      t_full();
      tally_and_finish();
   end
endmodule
